// [link_ctrl_regs.vh]
// Register offsets, field positions and reset values of the link control
// and node information register bank. Assumes byte addressing on APB.
`ifndef LINK_CTRL_REGS_VH
`define LINK_CTRL_REGS_VH

`define CTRL_SET_OFF         12'h050
`define CTRL_CLR_OFF         12'h054
`define BUF_BASE_OFF         12'h064
`define COUNT_STAT_OFF       12'h068

`define CTRL_LPS_BIT         19
`define CTRL_PWA_BIT         18
`define CTRL_LINK_BIT        17
`define CTRL_SRST_BIT        16

`define BUF_BASE_LSB         11
`define CNT_ERR_BIT          31
`define CNT_GEN_MSB          23
`define CNT_GEN_LSB          16
`define CNT_SIZE_MSB         10
`define CNT_SIZE_LSB         2

`define CTRL_RESET           4'h0
`define SRST_CYCLES          4'h8

`endif

// [link_control_node_info_regs.v]
// Register bank for link power, posted writes, link enable, software reset,
// the node information buffer base and the node information count/status.
// Assumes an APB master on pclk and a link core on the same clock that
// reports bus resets, quadlets written and reception outcomes as pulses.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`include "link_ctrl_regs.vh"

// Notes on behaviour
// - Power bit high lets link talk to PHY.
// - Bit 18 enables or disables posted writes.
// - Hardware and software reset clear link enable.
// - Link enable low blocks receive, process, transmit.
// - Software reset restores registers and flushes FIFOs.
// - Software reset bit reads one until done.
// - Control reserved bits read zero.
// - Buffer base holds bits 31-11, low zero.
// - Node info packets written at buffer base.
// - Error flag set on bad reception.
// - Error flag cleared by clean reception.
// - Hardware or host bus errors raise flag.
// - Generation counts bus resets, wraps at 255.
// - Size counts quadlets written this reception.
// - Size clears when reception begins.
// - Count reserved bits read zero.
// - Control set at 50h, clear at 54h.
module link_control_node_info_regs #(
   parameter SRST_LEN = `SRST_CYCLES
) (
   // APB slave.
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   // Link core events.
   input  wire        bus_reset_seen,
   input  wire        rx_begin,
   input  wire        quadlet_written,
   input  wire        rx_done,
   input  wire        rx_hw_error,
   input  wire        host_write_error,
   // Link core controls.
   output wire        link_phy_allow,
   output wire        posted_write_allow,
   output wire        link_active,
   output wire        soft_flush,
   output wire [31:0] node_info_write_addr
);

   // Control bits and their next values.
   reg        link_power_status_bit_q;
   reg        link_power_status_bit_d;
   reg        posted_write_allow_q;
   reg        posted_write_allow_d;
   reg        link_active_enable_q;
   reg        link_active_enable_d;
   reg        software_reset_bit_q;
   reg        software_reset_bit_d;
   reg [3:0]  srst_cnt_q;
   reg [3:0]  srst_cnt_d;

   // Buffer base, node information state and the next write address.
   reg [20:0] buf_base_q;
   reg [20:0] buf_base_d;
   reg        node_info_error_q;
   reg        node_info_error_d;
   reg        err_pending_q;
   reg        err_pending_d;
   reg [7:0]  bus_reset_generation_q;
   reg [7:0]  bus_reset_generation_d;
   reg [8:0]  node_info_quadlet_count_q;
   reg [8:0]  node_info_quadlet_count_d;
   reg [31:0] write_addr_q;
   reg [31:0] write_addr_d;

   // Read image, taken into prdata in the setup cycle.
   reg [31:0] prdata_d;

   // Last count value of a software reset.
   localparam [3:0] SRST_LAST = SRST_LEN[3:0] - 4'h1;

   // Compares a transfer address against one register offset.
   function addr_hit;
      input [11:0] addr;
      input [11:0] offset;
      begin
         addr_hit = (addr == offset);
      end
   endfunction

   // Builds a buffer byte address from a base and a quadlet index.
   function [31:0] buf_addr;
      input [20:0] base;
      input [8:0]  quadlets;
      begin
         buf_addr = {base, 11'h000} + {21'h00000, quadlets, 2'b00};
      end
   endfunction

   // Packs the control bits into their word positions.
   function [31:0] ctrl_image;
      input power_on;
      input posted_on;
      input linked_on;
      input resetting;
      begin
         ctrl_image = 32'h00000000;
         ctrl_image[`CTRL_LPS_BIT]  = power_on;
         ctrl_image[`CTRL_PWA_BIT]  = posted_on;
         ctrl_image[`CTRL_LINK_BIT] = linked_on;
         ctrl_image[`CTRL_SRST_BIT] = resetting;
      end
   endfunction

   // Packs the node information fields into their word positions.
   function [31:0] count_image;
      input       err;
      input [7:0] gen;
      input [8:0] size;
      begin
         count_image = 32'h00000000;
         count_image[`CNT_ERR_BIT]                = err;
         count_image[`CNT_GEN_MSB:`CNT_GEN_LSB]   = gen;
         count_image[`CNT_SIZE_MSB:`CNT_SIZE_LSB] = size;
      end
   endfunction

   wire       wr_en      = psel & penable & pwrite;
   wire       rd_setup   = psel & ~penable & ~pwrite;
   wire       wr_set     = wr_en & addr_hit(paddr, `CTRL_SET_OFF);
   wire       wr_clr     = wr_en & addr_hit(paddr, `CTRL_CLR_OFF);
   wire       wr_base    = wr_en & addr_hit(paddr, `BUF_BASE_OFF);
   wire       srst_done  = software_reset_bit_q &
                           (srst_cnt_q == SRST_LAST);
   wire       rx_enabled = link_active_enable_q & ~software_reset_bit_q;
   wire       rx_error   = rx_hw_error | host_write_error;

   assign pready  = 1'b1;
   assign pslverr = 1'b0;

   assign link_phy_allow = link_power_status_bit_q;
   assign posted_write_allow = posted_write_allow_q;
   assign link_active = rx_enabled;
   assign soft_flush = software_reset_bit_q;
   assign node_info_write_addr = write_addr_q;

   always @* begin
      link_power_status_bit_d = link_power_status_bit_q;
      posted_write_allow_d    = posted_write_allow_q;
      link_active_enable_d    = link_active_enable_q;
      software_reset_bit_d    = software_reset_bit_q;
      srst_cnt_d              = srst_cnt_q;
      if (software_reset_bit_q) begin
         link_power_status_bit_d = 1'b0;
         posted_write_allow_d    = 1'b0;
         link_active_enable_d    = 1'b0;
         srst_cnt_d              = srst_cnt_q + 4'h1;
         if (srst_done) begin
            software_reset_bit_d = 1'b0;
            srst_cnt_d           = 4'h0;
         end
      end else if (wr_set) begin
         link_power_status_bit_d = link_power_status_bit_q |
                                   pwdata[`CTRL_LPS_BIT];
         posted_write_allow_d    = posted_write_allow_q |
                                   pwdata[`CTRL_PWA_BIT];
         link_active_enable_d    = link_active_enable_q |
                                   pwdata[`CTRL_LINK_BIT];
         software_reset_bit_d    = pwdata[`CTRL_SRST_BIT];
      end else if (wr_clr) begin
         link_power_status_bit_d = link_power_status_bit_q &
                                   ~pwdata[`CTRL_LPS_BIT];
         posted_write_allow_d    = posted_write_allow_q &
                                   ~pwdata[`CTRL_PWA_BIT];
         link_active_enable_d    = link_active_enable_q &
                                   ~pwdata[`CTRL_LINK_BIT];
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {link_power_status_bit_q, posted_write_allow_q,
          link_active_enable_q, software_reset_bit_q} <= `CTRL_RESET;
         srst_cnt_q              <= 4'h0;
      end else begin
         link_power_status_bit_q <= link_power_status_bit_d;
         posted_write_allow_q    <= posted_write_allow_d;
         link_active_enable_q    <= link_active_enable_d;
         software_reset_bit_q    <= software_reset_bit_d;
         srst_cnt_q              <= srst_cnt_d;
      end
   end

   always @* begin
      buf_base_d = buf_base_q;
      if (software_reset_bit_q)
         buf_base_d = 21'h00000;
      else if (wr_base)
         buf_base_d = pwdata[31:`BUF_BASE_LSB];
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         buf_base_q <= 21'h00000;
      end else begin
         buf_base_q <= buf_base_d;
      end
   end

   // Errors during a reception are held until its outcome is known.
   always @* begin
      node_info_error_d         = node_info_error_q;
      err_pending_d             = err_pending_q;
      bus_reset_generation_d    = bus_reset_generation_q;
      node_info_quadlet_count_d = node_info_quadlet_count_q;
      if (software_reset_bit_q) begin
         node_info_error_d         = 1'b0;
         err_pending_d             = 1'b0;
         bus_reset_generation_d    = 8'h00;
         node_info_quadlet_count_d = 9'h000;
      end else if (rx_enabled) begin
         if (bus_reset_seen)
            bus_reset_generation_d = bus_reset_generation_q + 8'h01;
         if (rx_begin) begin
            node_info_quadlet_count_d = 9'h000;
            err_pending_d             = 1'b0;
         end else if (quadlet_written) begin
            node_info_quadlet_count_d = node_info_quadlet_count_q + 9'h001;
         end
         if (rx_done) begin
            node_info_error_d = err_pending_q | rx_error;
            err_pending_d     = 1'b0;
         end else if (rx_error) begin
            err_pending_d     = 1'b1;
            node_info_error_d = 1'b1;
         end
      end
   end

   // The address is built from next values so it never lags the count.
   always @* begin
      write_addr_d = buf_addr(buf_base_d, node_info_quadlet_count_d);
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         node_info_error_q         <= 1'b0;
         err_pending_q             <= 1'b0;
         bus_reset_generation_q    <= 8'h00;
         node_info_quadlet_count_q <= 9'h000;
         write_addr_q              <= 32'h00000000;
      end else begin
         node_info_error_q         <= node_info_error_d;
         err_pending_q             <= err_pending_d;
         bus_reset_generation_q    <= bus_reset_generation_d;
         node_info_quadlet_count_q <= node_info_quadlet_count_d;
         write_addr_q              <= write_addr_d;
      end
   end

   // Read image; reserved bits and unmapped addresses read zero.
   always @* begin
      prdata_d = 32'h00000000;
      case (paddr)
         `CTRL_SET_OFF, `CTRL_CLR_OFF:
            prdata_d = ctrl_image(link_power_status_bit_q,
                                  posted_write_allow_q,
                                  link_active_enable_q,
                                  software_reset_bit_q);
         `BUF_BASE_OFF:
            prdata_d = {buf_base_q, 11'h000};
         `COUNT_STAT_OFF:
            prdata_d = count_image(node_info_error_q,
                                   bus_reset_generation_q,
                                   node_info_quadlet_count_q);
         default:
            prdata_d = 32'h00000000;
      endcase
   end

   // The image is taken at the setup edge and stands through the access
   // phase, so a read returns state one cycle old; it clears to zero at the
   // edge after any idle or write setup cycle.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (rd_setup) begin
         prdata <= prdata_d;
      end else if (!(psel & penable)) begin
         prdata <= 32'h00000000;
      end
   end

endmodule

// [link_ctrl_checker.sv]
// Concurrent checks on the ports of the link control register bank.
// Assumes it is bound to every instance of that bank, default SRST_LEN.
`timescale 1ns/1ps
module link_ctrl_checker (
   input wire        pclk, presetn, psel, penable, pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata, prdata, node_info_write_addr,
   input wire        link_active, soft_flush, rx_begin, quadlet_written
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire rd  = psel && penable && !pwrite;
   wire wr  = psel && penable && pwrite;
   wire ctl = paddr == 12'h050 || paddr == 12'h054;
   a_ctrl_rsvd: assert property (rd && ctl |->
      prdata[31:20] == 0 && prdata[15:0] == 0) else $error("ctrl rsvd");
   a_count_rsvd: assert property (rd && paddr == 12'h068 |->
      prdata[30:24] == 0 && prdata[15:11] == 0 && prdata[1:0] == 0)
      else $error("count rsvd");
   a_set_link: assert property (wr && paddr == 12'h050 &&
      pwdata[17:16] == 2'h2 && !soft_flush |=> link_active)
      else $error("link not set");
   a_clear_link: assert property (wr && paddr == 12'h054 &&
      pwdata[17] |=> !link_active) else $error("link not cleared");
   a_reset_drops: assert property ($rose(soft_flush) |->
      !link_active [*2]) else $error("link alive in reset");
   a_reset_ends: assert property ($rose(soft_flush) |->
      ##[1:16] !soft_flush) else $error("reset stuck");
   a_reset_length: assert property ($rose(soft_flush) |->
      soft_flush [*8] ##1 !soft_flush) else $error("reset length");
   a_addr_step: assert property (link_active && quadlet_written &&
      !rx_begin |=> node_info_write_addr ==
      $past(node_info_write_addr) + 32'h4) else $error("addr step");
   a_begin_clear: assert property (link_active && rx_begin |=>
      node_info_write_addr[10:0] == 11'h0) else $error("size not cleared");
   cover property ($rose(soft_flush));
   cover property (link_active && quadlet_written);
   cover property (rd && paddr == 12'h068);
endmodule
bind link_control_node_info_regs link_ctrl_checker i_chk (.*);

// [link_core_model.sv]
// Behavioural link core that issues one-cycle event pulses to the bank.
// Assumes the bench calls fire from its main sequence on pclk.
`timescale 1ns/1ps
module link_core_model (
   input  wire       pclk,
   output reg  [5:0] ev
);
   initial ev = 6'h00;
   task fire(input [5:0] v, input integer n);
      repeat (n) begin
         @(posedge pclk);
         ev <= v;
         @(posedge pclk);
         ev <= 6'h00;
      end
   endtask
endmodule

// [tb.sv]
// Self-checking bench for the link control and node information bank.
// Assumes a zero-wait APB slave and the link core model on one clock.
`timescale 1ns/1ps
module tb;
   reg         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   reg  [11:0] paddr = 12'h000;
   reg  [31:0] pwdata = 32'h0, q;
   wire [31:0] prdata, addr;
   wire [5:0]  ev;
   wire        pready, lpa, pwa, act, sfl, perr;
   integer     err_count = 0, n_checks = 0, cyc = 0, i;
   always #5 pclk = ~pclk;
   link_core_model i_core (.pclk(pclk), .ev(ev));
   link_control_node_info_regs i_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(perr), .bus_reset_seen(ev[0]),
      .rx_begin(ev[1]), .quadlet_written(ev[2]), .rx_done(ev[3]),
      .rx_hw_error(ev[4]), .host_write_error(ev[5]),
      .link_phy_allow(lpa), .posted_write_allow(pwa), .link_active(act),
      .soft_flush(sfl), .node_info_write_addr(addr));
   task chk(input string nm, input [31:0] s, input [31:0] e);
      n_checks = n_checks + 1;
      if (s !== e) begin
         err_count = err_count + 1;
         $display("Error %0s expected %h seen %h", nm, e, s);
      end
   endtask
   task xfer(input w, input [11:0] a, input [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rc(input [11:0] a, input [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk($sformatf("reg %h", a), q, e);
   endtask
   task end_of_test;
      $display("Checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         err_count = err_count + 1;
         end_of_test;
      end
   end
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rc(12'h050, 32'h0);
      rc(12'h068, 32'h0);
      rc(12'h100, 32'h0);
      chk("slave error", perr, 32'h0);
      $display("Test reset values done");
      xfer(1'b1, 12'h050, 32'hFFFCFFFF);
      xfer(1'b1, 12'h050, 32'h00020000);
      rc(12'h054, 32'h000E0000);
      chk("outputs", {lpa, pwa, act}, 32'h7);
      xfer(1'b1, 12'h054, 32'h00080000);
      rc(12'h050, 32'h00060000);
      chk("phy allow", lpa, 32'h0);
      xfer(1'b1, 12'h064, 32'hFFFFFFFF);
      xfer(1'b1, 12'h068, 32'hFFFFFFFF);
      rc(12'h064, 32'hFFFFF800);
      rc(12'h068, 32'h0);
      $display("Test control and base done");
      i_core.fire(6'h01, 257);
      i_core.fire(6'h02, 1);
      i_core.fire(6'h04, 3);
      i_core.fire(6'h08, 1);
      rc(12'h068, 32'h0001000C);
      chk("write addr", addr, 32'hFFFFF80C);
      for (i = 4; i < 6; i = i + 1) begin
         i_core.fire(6'h02, 1);
         i_core.fire(6'h01 << i, 1);
         i_core.fire(6'h08, 1);
         rc(12'h068, 32'h80010000);
      end
      i_core.fire(6'h02, 1);
      i_core.fire(6'h04, 1);
      i_core.fire(6'h08, 1);
      rc(12'h068, 32'h00010004);
      xfer(1'b1, 12'h054, 32'h00020000);
      i_core.fire(6'h01, 1);
      i_core.fire(6'h04, 1);
      rc(12'h068, 32'h00010004);
      chk("link active", act, 32'h0);
      $display("Test node info done");
      xfer(1'b1, 12'h050, 32'h00010000);
      rc(12'h050, 32'h00010000);
      chk("flush", sfl, 32'h1);
      repeat (16) @(posedge pclk);
      rc(12'h050, 32'h0);
      chk("flush end", sfl, 32'h0);
      rc(12'h064, 32'h0);
      rc(12'h068, 32'h0);
      $display("Test soft reset done");
      xfer(1'b1, 12'h050, 32'h000E0000);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rc(12'h050, 32'h0);
      chk("link after reset", act, 32'h0);
      $display("Test hardware reset done");
      end_of_test;
   end
endmodule
